/* verilog/phy_event_irq.v */
`timescale 1ns/100ps
`include "phy_event_defines.vh"

// Summary of operation
// [R1] Jabber event gated by enable bit 7, receive error by bit 6; reset zero.
// [R2] Page received gated by enable bit 5, parallel fault by bit 4.
// [R3] Enable bits 3..0 gate acknowledge, link down, remote fault, link up.
// [R4] Low eight enable bits are read-write and reset to zero.
// [R5] Flag 10 sets on wake from deep power down; read-only, self-clearing. Here a write of one clears it; it self-clears only with bit 12 or 14.
// [R6] Flag 9 sets on entry into deep power down; read-only, self-clearing. Here a write of one clears it; it self-clears only with bit 12 or 14.
// [R7] Flag 8 sets when auto-negotiation completes.
// [R8] Flag 7 sets on jabber, flag 6 on receive error.
// [R9] Flag 5 sets on page received, flag 4 on parallel detect fault.
// [R10] Flag 3 sets on link-partner acknowledge.
// [R11] Flag 2 sets on link down, flag 0 on link up.
// [R12] Flag 1 sets on remote fault indication.
// [R13] Deep power down entered only while power-down bit 8 is set.
// [R14] PLL powered down in deep power down only if bit 7 set.
// [R15] 100 Mb receiver powered down in deep power down only if bit 6 set.
// [R16] Transmit DAC powered down in deep power down only if bit 5 set.
// [R17] Clock recovery powered down in deep power down only if bit 4 set.
// [R18] Enable bits 10, 9, 8 gate wake, power-down, negotiation events.
// [R19] With bit 14 set, reading the flag register clears flags.
// [R20] With bit 12 set, a flag clears when its condition goes away.
// [R21] Bit 13 selects interrupt output polarity, clear means active low.
// [R22] Interrupt asserted when output enabled and any enabled flag set.
module phy_event_irq (
   input  wire        clk_i,
   input  wire        rst_n_i,
   input  wire        reg_wr_i,
   input  wire        reg_rd_i,
   input  wire [4:0]  reg_addr_i,
   input  wire [15:0] reg_wdata_i,
   output reg  [15:0] reg_rdata_o,
   input  wire        link_idle_i,
   input  wire        link_up_i,
   input  wire        aneg_done_i,
   input  wire        jabber_i,
   input  wire        rx_error_i,
   input  wire        page_rx_i,
   input  wire        par_fault_i,
   input  wire        lp_ack_i,
   input  wire        remote_fault_i,
   output reg         irq_o,
   output reg         deep_power_down_o,
   output reg         rate_clock_pll_pd_o,
   output reg         rx100_pd_o,
   output reg         tx_dac_pd_o,
   output reg         clock_data_recovery_block_pd_o
);

   reg         rst_s1_q;
   reg         rst_s2_q;
   wire        rst_n;
   reg  [8:0]  pin1_q;
   reg  [8:0]  pin2_q;
   reg  [8:0]  cond_q;
   reg  [15:0] ien_q;
   reg  [15:0] pdc_q;
   reg  [10:0] flag_q;
   reg  [10:0] flag_d;
   reg  [10:0] cond;
   reg  [10:0] rise;
   reg         dpd_q;
   reg         dpd_prev_q;
   wire        flag_rd;
   wire        flag_wr;
   wire        ien_wr;
   wire        pdc_wr;
   wire        irq_active;
   integer     i;

   function sel;
      input [4:0] a;
      input [4:0] b;
      begin
         sel = (a == b);
      end
   endfunction

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end
   assign rst_n = rst_s2_q;

   // First synchroniser stage for event pins
   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         pin1_q <= 9'h000;
      end else begin
         pin1_q <= {link_idle_i, aneg_done_i, jabber_i, rx_error_i,
                    page_rx_i, par_fault_i, lp_ack_i, remote_fault_i,
                    link_up_i};
      end
   end

   // Second synchroniser stage
   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         pin2_q <= 9'h000;
      end else begin
         pin2_q <= pin1_q;
      end
   end

   // Previous condition levels for edge detection
   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         cond_q <= 9'h000;
      end else begin
         cond_q <= pin2_q;
      end
   end

   // Deep power down state follows idle link when enabled
   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         dpd_q <= 1'b0;
      end else begin
         dpd_q <= pdc_q[`PDC_DPD_ENABLE] & pin2_q[8]; // [R13]
      end
   end

   // Previous power-down state for entry and wake edges
   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         dpd_prev_q <= 1'b0;
      end else begin
         dpd_prev_q <= dpd_q;
      end
   end

   // Event condition levels
   always @* begin
      cond[0]  = pin2_q[0];                          // [R11]
      cond[1]  = pin2_q[1];                          // [R12]
      cond[2]  = ~pin2_q[0];                         // [R11]
      cond[3]  = pin2_q[2];                          // [R10]
      cond[4]  = pin2_q[3];                          // [R9]
      cond[5]  = pin2_q[4];                          // [R9]
      cond[6]  = pin2_q[5];                          // [R8]
      cond[7]  = pin2_q[6];                          // [R8]
      cond[8]  = pin2_q[7];                          // [R7]
      cond[`EVT_DPD_ENTER] = dpd_q;                  // [R6]
      cond[`EVT_WAKE]      = ~dpd_q;                 // [R5]
      rise[0]  = pin2_q[0] & ~cond_q[0];
      rise[1]  = pin2_q[1] & ~cond_q[1];
      rise[2]  = ~pin2_q[0] & cond_q[0];
      rise[3]  = pin2_q[2] & ~cond_q[2];
      rise[4]  = pin2_q[3] & ~cond_q[3];
      rise[5]  = pin2_q[4] & ~cond_q[4];
      rise[6]  = pin2_q[5] & ~cond_q[5];
      rise[7]  = pin2_q[6] & ~cond_q[6];
      rise[8]  = pin2_q[7] & ~cond_q[7];
      rise[`EVT_DPD_ENTER] = dpd_q & ~dpd_prev_q;
      rise[`EVT_WAKE]      = ~dpd_q & dpd_prev_q;
   end

   assign flag_rd = reg_rd_i & sel(reg_addr_i, `ADDR_IRQ_FLAGS);
   assign flag_wr = reg_wr_i & sel(reg_addr_i, `ADDR_IRQ_FLAGS);

   // Flag update: set wins over every clear
   always @* begin
      flag_d = flag_q;
      for (i = 0; i < `NUM_EVENTS; i = i + 1) begin
         if (flag_rd && ien_q[`IEN_READ_CLEAR]) begin
            flag_d[i] = 1'b0; // [R19]
         end
         if (flag_wr && reg_wdata_i[i] &&
             !(ien_q[`IEN_RESETUP] && cond[i])) begin
            flag_d[i] = 1'b0;
         end
         if (ien_q[`IEN_AUTO_CLEAR] && !cond[i]) begin
            flag_d[i] = 1'b0; // [R20]
         end
         if (rise[i]) begin
            flag_d[i] = 1'b1;
         end
      end
   end

   // Register write decodes
   assign ien_wr = reg_wr_i & sel(reg_addr_i, `ADDR_IRQ_ENABLE);
   assign pdc_wr = reg_wr_i & sel(reg_addr_i, `ADDR_POWER_DOWN);

   // Read data selection
   function [15:0] read_mux;
      input [4:0]  a;
      input [15:0] ien;
      input [15:0] pdc;
      input [10:0] flags;
      begin
         case (a)
            `ADDR_IRQ_ENABLE: read_mux = ien;
            `ADDR_IRQ_FLAGS:  read_mux = {5'h00, flags};
            `ADDR_POWER_DOWN: read_mux = pdc;
            default:          read_mux = 16'h0000;
         endcase
      end
   endfunction

   // Event flag register
   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         flag_q <= 11'h000;
      end else begin
         flag_q <= flag_d;
      end
   end

   // Interrupt enable register
   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ien_q <= `IEN_RESET; // [R4]
      end else begin
         if (ien_wr) begin
            ien_q <= reg_wdata_i; // [R4]
         end
      end
   end

   // Power-down control register
   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         pdc_q <= `PDC_RESET;
      end else begin
         if (pdc_wr) begin
            pdc_q <= reg_wdata_i & `PDC_RW_MASK;
         end
      end
   end

   // Enables gate flags onto the interrupt
   assign irq_active = ien_q[`IEN_OUT_ENABLE] &
                       (|(flag_q & ien_q[10:0])); // [R1] [R2] [R3] [R18] [R22]

   // Interrupt pin with selectable polarity
   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= irq_active ~^ ien_q[`IEN_POLARITY]; // [R21]
      end
   end

   // Deep power down status
   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         deep_power_down_o <= 1'b0;
      end else begin
         deep_power_down_o <= dpd_q; // [R13]
      end
   end

   // PLL power down
   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         rate_clock_pll_pd_o <= 1'b0;
      end else begin
         rate_clock_pll_pd_o <= dpd_q & pdc_q[`PDC_PLL]; // [R14]
      end
   end

   // 100 Mb receiver power down
   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         rx100_pd_o <= 1'b0;
      end else begin
         rx100_pd_o <= dpd_q & pdc_q[`PDC_RX100]; // [R15]
      end
   end

   // Transmit DAC power down
   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         tx_dac_pd_o <= 1'b0;
      end else begin
         tx_dac_pd_o <= dpd_q & pdc_q[`PDC_TX_DAC]; // [R16]
      end
   end

   // Clock recovery power down
   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         clock_data_recovery_block_pd_o <= 1'b0;
      end else begin
         clock_data_recovery_block_pd_o <= dpd_q & pdc_q[`PDC_CDR]; // [R17]
      end
   end

   // Read data, held until the next read
   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_o <= 16'h0000;
      end else begin
         if (reg_rd_i) begin
            reg_rdata_o <= read_mux(reg_addr_i, ien_q, pdc_q, flag_q);
         end
      end
   end

endmodule

/* verilog/phy_event_defines.vh */
`ifndef PHY_EVENT_DEFINES_VH
`define PHY_EVENT_DEFINES_VH
`define ADDR_IRQ_ENABLE      5'h16
`define ADDR_IRQ_FLAGS       5'h17
`define ADDR_POWER_DOWN      5'h18
`define IEN_OUT_ENABLE       15
`define IEN_READ_CLEAR       14
`define IEN_POLARITY         13
`define IEN_AUTO_CLEAR       12
`define IEN_RESETUP          11
`define PDC_DPD_ENABLE       8
`define PDC_PLL              7
`define PDC_RX100            6
`define PDC_TX_DAC           5
`define PDC_CDR              4
`define IEN_RESET            16'h0000
`define PDC_RESET            16'h2000
`define PDC_RW_MASK          16'hfff0
`define NUM_EVENTS           11
`define EVT_WAKE             10
`define EVT_DPD_ENTER        9
`endif

/* bench/phy_event_checker.sv */
`timescale 1ns/100ps
module phy_event_checker (
   input wire        clk_i,
   input wire        rst_n_i,
   input wire        reg_wr_i,
   input wire        reg_rd_i,
   input wire [4:0]  reg_addr_i,
   input wire [15:0] reg_wdata_i,
   input wire [15:0] reg_rdata_o,
   input wire        irq_o,
   input wire        deep_power_down_o,
   input wire        rate_clock_pll_pd_o,
   input wire        rx100_pd_o,
   input wire        tx_dac_pd_o,
   input wire        clock_data_recovery_block_pd_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   a_pll_needs_dpd: assert property (
      rate_clock_pll_pd_o |-> deep_power_down_o) else $error("pll off");
   a_rx_needs_dpd: assert property (
      rx100_pd_o |-> deep_power_down_o) else $error("rx off");
   a_dac_needs_dpd: assert property (
      tx_dac_pd_o |-> deep_power_down_o) else $error("dac off");
   a_cdr_needs_dpd: assert property (
      clock_data_recovery_block_pd_o |-> deep_power_down_o)
      else $error("cdr off");
   a_unmapped_reads_zero: assert property (
      reg_rd_i && (reg_addr_i < 5'h16 || reg_addr_i > 5'h18)
      |=> reg_rdata_o == 16'h0000) else $error("unmapped read");
   a_flag_top_zero: assert property (
      reg_rd_i && reg_addr_i == 5'h17 |=> reg_rdata_o[15:11] == 5'h00)
      else $error("flag reserved bits");
   a_pdc_low_zero: assert property (
      reg_rd_i && reg_addr_i == 5'h18 |=> reg_rdata_o[3:0] == 4'h0)
      else $error("pdc reserved bits");
   a_irq_idle_level: assert property (
      reg_wr_i && reg_addr_i == 5'h16 && !reg_wdata_i[15] ##1 !reg_wr_i
      |=> irq_o == ~$past(reg_wdata_i[13], 2)) else $error("idle level");
endmodule
bind phy_event_irq phy_event_checker chk_u (.clk_i, .rst_n_i, .reg_wr_i,
   .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .irq_o,
   .deep_power_down_o, .rate_clock_pll_pd_o, .rx100_pd_o, .tx_dac_pd_o,
   .clock_data_recovery_block_pd_o);

/* bench/sta_model.sv */
`timescale 1ns/100ps
module sta_model (
   input  wire        clk_i,
   output reg         reg_wr_o,
   output reg         reg_rd_o,
   output reg  [4:0]  reg_addr_o,
   output reg  [15:0] reg_wdata_o,
   input  wire [15:0] reg_rdata_i
);
   initial {reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = 23'h0;
   task wr(input [4:0] a, input [15:0] d);
      begin
         @(posedge clk_i);
         reg_wr_o <= 1'h1;
         reg_addr_o <= a;
         reg_wdata_o <= d;
         @(posedge clk_i);
         reg_wr_o <= 1'h0;
         reg_addr_o <= ~a;
         reg_wdata_o <= ~d;
      end
   endtask
   task rd(input [4:0] a, output [15:0] d);
      begin
         @(posedge clk_i);
         reg_rd_o <= 1'h1;
         reg_addr_o <= a;
         @(posedge clk_i);
         reg_rd_o <= 1'h0;
         reg_addr_o <= ~a;
         #1 d = reg_rdata_i;
      end
   endtask
endmodule

/* bench/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
   reg         clk_i = 1'h0;
   reg         rst_n_i = 1'h0;
   reg  [8:0]  ev_q = 9'h0;
   reg         idle_q = 1'h0;
   reg         pol;
   wire        wr, rd, irq, deep_power_down;
   wire [4:0]  addr;
   wire [15:0] wdata, rdata;
   wire [3:0]  pd;
   reg  [15:0] d, x;
   integer     n_fail = 0, total_checks = 0, i;
   always #12.5 clk_i = ~clk_i;
   sta_model m (.clk_i(clk_i), .reg_wr_o(wr), .reg_rd_o(rd),
      .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_rdata_i(rdata));
   phy_event_irq dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_wr_i(wr),
      .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_rdata_o(rdata), .link_idle_i(idle_q),
      .link_up_i(ev_q[0] ^ ev_q[2]), .aneg_done_i(ev_q[8]),
      .jabber_i(ev_q[7]), .rx_error_i(ev_q[6]), .page_rx_i(ev_q[5]),
      .par_fault_i(ev_q[4]), .lp_ack_i(ev_q[3]), .remote_fault_i(ev_q[1]),
      .irq_o(irq), .deep_power_down_o(deep_power_down), .rate_clock_pll_pd_o(pd[3]),
      .rx100_pd_o(pd[2]), .tx_dac_pd_o(pd[1]),
      .clock_data_recovery_block_pd_o(pd[0]));
   function [15:0] pd_exp(input on, input [15:0] v);
      pd_exp = on ? (16'h0010 | (v >> 4)) : 16'h0000;
   endfunction
   task chk(input [15:0] got, input [15:0] exp);
      begin
         total_checks = total_checks + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task print_verdict;
      begin
         $display("checks=%0d fails=%0d", total_checks, n_fail);
         if (n_fail == 0 && total_checks > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask
   task settle;
      begin
         repeat (6) @(posedge clk_i);
         #1;
      end
   endtask
   initial begin
      #2000000;
      n_fail = n_fail + 1;
      print_verdict;
   end
   initial begin
      x = $urandom(55303);
      repeat (12) @(posedge clk_i);
      rst_n_i <= 1'h1;
      repeat (3) @(posedge clk_i);
      m.rd(5'h16, d); chk(d, 16'h0000);
      m.rd(5'h17, d); chk(d, 16'h0000);
      m.rd(5'h18, d); chk(d, 16'h2000);
      m.rd(5'h10, d); chk(d, 16'h0000);
      x = $urandom & 16'h7fff;
      m.wr(5'h16, x);
      m.rd(5'h16, d); chk(d, x);
      for (i = 0; i < 9; i = i + 1) begin
         pol = $urandom;
         m.wr(5'h16, 16'hc000 | ({15'h0, pol} << 13) | (16'h1 << i));
         @(posedge clk_i);
         #1 chk({15'h0, irq}, {15'h0, ~pol});
         @(posedge clk_i);
         ev_q <= ev_q ^ (9'h1 << i);
         settle;
         chk({15'h0, irq}, {15'h0, pol});
         m.rd(5'h17, d); chk(d, 16'h1 << i);
         m.rd(5'h17, d); chk(d, 16'h0000);
      end
      m.wr(5'h16, 16'h9001);
      @(posedge clk_i);
      ev_q <= ev_q ^ 9'h001;
      settle;
      chk({15'h0, irq}, 16'h0000);
      @(posedge clk_i);
      ev_q <= ev_q ^ 9'h001;
      settle;
      m.rd(5'h17, d); chk(d, 16'h0004);
      m.rd(5'h17, d); chk(d, 16'h0004);
      m.wr(5'h17, 16'h0004);
      m.rd(5'h17, d); chk(d, 16'h0000);
      x = $urandom & 16'h00f0;
      m.wr(5'h16, 16'hc600);
      m.wr(5'h18, 16'h20f0);
      @(posedge clk_i);
      idle_q <= 1'h1;
      settle;
      chk({11'h0, deep_power_down, pd}, pd_exp(1'h0, x));
      m.wr(5'h18, 16'h2100 | x);
      settle;
      chk({11'h0, deep_power_down, pd}, pd_exp(1'h1, x));
      chk({15'h0, irq}, 16'h0000);
      m.rd(5'h17, d); chk(d, 16'h0200);
      @(posedge clk_i);
      idle_q <= 1'h0;
      settle;
      m.rd(5'h17, d); chk(d, 16'h0400);
      @(posedge clk_i);
      rst_n_i <= 1'h0;
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1'h1;
      repeat (3) @(posedge clk_i);
      m.rd(5'h16, d); chk(d, 16'h0000);
      m.rd(5'h18, d); chk(d, 16'h2000);
      chk({15'h0, irq}, 16'h0001);
      print_verdict;
   end
endmodule
